// ---- bench/test_soft_error_reporting.sv ----
// Self-checking bench for the soft error reporting block: reset values,
// then a table of single error events, then hand-written hold, mask,
// dispatch, control, unmapped and mid-run reset cases.
// Assumes ser_top answers Wishbone one cycle after the taken edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   $display("MISMATCH %s exp %h got %h", n, e, g); errors++; end end
module test_soft_error_reporting;
   // Table row: event vector, status, capture offset, {abort, fwd}
   typedef struct {logic [12:0] ev; logic [10:0] st; logic [7:0] off;
      logic [1:0] pl;} ser_row_t;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, take_i;
   logic [7:0] wb_adr_i, fill_syn_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, pc_i, psl_i, ic_vaddr_i, pc_paddr_i, fill_addr_i;
   // Event bits: ic 3:0, pc data/left/right 6:4, fill 8:7, pte 10:9,
   // reference valid 11, miss 12
   logic [12:0] ev;
   wire logic [31:0] wb_dat_o, push_data_o;
   wire logic wb_ack_o, int_o, ic_enable_o, pc_enable_o, pc_fwd_miss_o;
   wire logic write_abort_o, irq_req_o, push_o;
   wire logic [4:0] irq_ipl_o;
   wire logic [7:0] irq_vec_o;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [31:0] q, a;
   int n;
   // Offset 8'hFF means no capture register to read
   ser_row_t rows [16] = '{
      '{13'h0001, 11'h401, 8'h0C, 2'h0}, '{13'h0002, 11'h402, 8'h0C, 2'h0},
      '{13'h0004, 11'h404, 8'h0C, 2'h0}, '{13'h0008, 11'h408, 8'h0C, 2'h0},
      '{13'h0810, 11'h210, 8'h10, 2'h1}, '{13'h0020, 11'h220, 8'h10, 2'h0},
      '{13'h0040, 11'h240, 8'h10, 2'h0}, '{13'h0060, 11'h260, 8'h10, 2'h0},
      '{13'h0030, 11'h220, 8'h10, 2'h0}, '{13'h0180, 11'h080, 8'h14, 2'h0},
      '{13'h0080, 11'h000, 8'hFF, 2'h0}, '{13'h0600, 11'h100, 8'hFF, 2'h2},
      '{13'h0200, 11'h000, 8'hFF, 2'h0}, '{13'h1800, 11'h000, 8'hFF, 2'h1},
      '{13'h0800, 11'h000, 8'hFF, 2'h0}, '{13'h0009, 11'h409, 8'h0C, 2'h0}};

   ser_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .int_o(int_o), .ic_icache_data_parity_bank_zero_i(ev[0]),
      .ic_icache_tag_parity_bank_zero_i(ev[1]), .ic_icache_data_parity_bank_one_i(ev[2]), .ic_icache_tag_parity_bank_one_i(ev[3]),
      .ic_vaddr_i(ic_vaddr_i), .ic_enable_o(ic_enable_o),
      .pc_ref_valid_i(ev[11]), .pc_miss_i(ev[12]), .pc_dperr_i(ev[4]),
      .pc_tperr_left_i(ev[5]), .pc_tperr_right_i(ev[6]),
      .pc_paddr_i(pc_paddr_i), .pc_enable_o(pc_enable_o),
      .pc_fwd_miss_o(pc_fwd_miss_o), .fill_err_i(ev[7]),
      .fill_multi_i(ev[8]), .fill_addr_i(fill_addr_i),
      .fill_syn_i(fill_syn_i), .pte_err_i(ev[9]), .pte_write_i(ev[10]),
      .write_abort_o(write_abort_o), .take_i(take_i), .pc_i(pc_i),
      .psl_i(psl_i), .irq_req_o(irq_req_o), .irq_ipl_o(irq_ipl_o),
      .irq_vec_o(irq_vec_o), .push_o(push_o), .push_data_o(push_data_o));

   // Free-running 20 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Counts the run and ends a hang
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end

   // Counts, then one verdict line
   task give_verdict;
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // Classic single Wishbone cycle; waits for ack, bounded
   task wb(input logic we, input logic [7:0] ad, input logic [31:0] d,
         output logic [31:0] r);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= ad;
      wb_dat_i <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      r = wb_dat_o;
      if (k >= 20) errors++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   // One-cycle event pulse with its address and syndrome
   task pulse(input logic [12:0] e, input logic [31:0] ad);
      @(posedge clk_i);
      ev <= e;
      ic_vaddr_i <= ad;
      pc_paddr_i <= ad;
      fill_addr_i <= ad;
      fill_syn_i <= ad[7:0] ^ 8'hA5;
      @(posedge clk_i);
      ev <= '0;
   endtask : pulse

   // Main sequence
   initial begin
      rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
      wb_adr_i = '0; wb_sel_i = 4'hF; wb_dat_i = '0; take_i = 1'b0;
      pc_i = 32'hC0DE_0100; psl_i = 32'h041F_0000; ev = '0;
      ic_vaddr_i = '0; pc_paddr_i = '0; fill_addr_i = '0; fill_syn_i = '0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, ser_pkg::OFF_STATUS, 0, q); `CHK("status", 11'h000, q[10:0])
      wb(0, ser_pkg::OFF_MASK, 0, q); `CHK("mask", 11'h1FF, q[10:0])
      wb(0, ser_pkg::OFF_CTRL, 0, q); `CHK("ctrl", 2'h3, q[1:0])
      `CHK("int", 1'b0, int_o)
      $display("reset values done");
      // Table of single events
      for (int i = 0; i < 16; i++) begin
         a = 32'h8000_1007 + 32'(i * 16);
         pulse(rows[i].ev, a);
         @(negedge clk_i);
         `CHK("fwd_miss", rows[i].pl[0], pc_fwd_miss_o)
         `CHK("abort", rows[i].pl[1], write_abort_o)
         repeat (2) @(posedge clk_i);
         `CHK("int", |rows[i].st[8:0], int_o)
         `CHK("pc_en", ~rows[i].st[9], pc_enable_o)
         `CHK("ic_en", ~rows[i].st[10], ic_enable_o)
         wb(0, ser_pkg::OFF_STATUS, 0, q);
         `CHK("status", rows[i].st, q[10:0])
         if (rows[i].off != 8'hFF) begin
            wb(0, rows[i].off, 0, q);
            if (rows[i].off == ser_pkg::OFF_IC_ADDR) a = a & ~32'h7;
            `CHK("addr", a, q)
         end
         if (rows[i].off == ser_pkg::OFF_FILL_ADDR) begin
            wb(0, ser_pkg::OFF_FILL_SYN, 0, q);
            `CHK("syndrome", a[7:0] ^ 8'hA5, q[7:0])
         end
         wb(1, ser_pkg::OFF_STATUS, 32'h7FF, q);
         wb(0, ser_pkg::OFF_STATUS, 0, q);
         `CHK("cleared", 11'h000, q[10:0])
         `CHK("pc_en", 1'b1, pc_enable_o)
         $display("row %0d done", i);
      end
      // First capture holds against a later error
      pulse(13'h0020, 32'h1111_0000);
      pulse(13'h0010, 32'h2222_0000);
      wb(0, ser_pkg::OFF_PC_ADDR, 0, q); `CHK("hold", 32'h1111_0000, q)
      wb(0, ser_pkg::OFF_STATUS, 0, q); `CHK("both", 11'h230, q[10:0])
      wb(1, ser_pkg::OFF_STATUS, 32'h7FF, q);
      $display("hold done");
      // Masked event, then unmasked, then dispatch
      wb(1, ser_pkg::OFF_MASK, 0, q);
      pulse(13'h0001, 32'h0);
      repeat (3) @(posedge clk_i);
      `CHK("masked", 1'b0, int_o)
      wb(1, ser_pkg::OFF_MASK, 32'h1FF, q);
      n = 0;
      while (irq_req_o !== 1'b1 && n < 10) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("int", 1'b1, int_o)
      `CHK("req", 1'b1, irq_req_o)
      `CHK("ipl", 5'h1A, irq_ipl_o)
      `CHK("vec", 8'h54, irq_vec_o)
      @(posedge clk_i);
      take_i <= 1'b1;
      @(posedge clk_i);
      take_i <= 1'b0;
      @(negedge clk_i);
      `CHK("req_drop", 1'b0, irq_req_o)
      `CHK("push_pc", 33'h1_C0DE_0100, {push_o, push_data_o})
      @(negedge clk_i);
      `CHK("push_psl", 33'h1_041F_0000, {push_o, push_data_o})
      @(negedge clk_i);
      `CHK("push_end", 1'b0, push_o)
      wb(1, ser_pkg::OFF_STATUS, 32'h7FF, q);
      repeat (3) @(posedge clk_i);
      `CHK("int_clr", 1'b0, int_o)
      `CHK("req_clr", 1'b0, irq_req_o)
      $display("interrupt done");
      // Icache error: software disables, clears the lock, re-enables
      pulse(13'h0001, 32'h0);
      wb(1, ser_pkg::OFF_CTRL, 0, q);
      @(negedge clk_i);
      `CHK("en_off", 2'h0, {ic_enable_o, pc_enable_o})
      wb(1, ser_pkg::OFF_STATUS, 32'h7FF, q);
      @(negedge clk_i);
      `CHK("en_held", 2'h0, {ic_enable_o, pc_enable_o})
      wb(1, ser_pkg::OFF_CTRL, 32'h3, q);
      @(negedge clk_i);
      `CHK("en_on", 2'h3, {ic_enable_o, pc_enable_o})
      // Unmapped offset acks, ignores writes, reads zero
      wb(1, 8'h1C, 32'hFFFF_FFFF, q);
      wb(0, 8'h1C, 0, q); `CHK("unmapped", 32'h0, q)
      $display("control done");
      // Reset in mid-run clears a live flag and restores the mask
      wb(1, ser_pkg::OFF_MASK, 0, q);
      pulse(13'h0001, 32'h0);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, ser_pkg::OFF_STATUS, 0, q); `CHK("rst_st", 11'h000, q[10:0])
      `CHK("rst_int", 1'b0, int_o)
      `CHK("rst_en", 2'h3, {ic_enable_o, pc_enable_o})
      wb(0, ser_pkg::OFF_MASK, 0, q); `CHK("rst_mask", 11'h1FF, q[10:0])
      $display("second reset done");
      give_verdict();
   end
endmodule : test_soft_error_reporting
`default_nettype wire

// ---- src/ser_capture.sv ----
// Holding register for one captured address or syndrome.
// Assumes the caller decides when a capture is allowed.
`timescale 1ns/1ps
`default_nettype none
module ser_capture #(
   parameter int W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [W-1:0] data_i,
   output logic [W-1:0] q_o
);
   // Whole state of the holder
   typedef struct packed {
      logic [W-1:0] q;
   } ser_cap_st_t;

   ser_cap_st_t st;
   ser_cap_st_t next_st;

   // Load only on request, otherwise hold
   always_comb begin
      next_st = st;
      if (load_i) begin
         next_st.q = data_i;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.q;
endmodule : ser_capture
`default_nettype wire

// ---- src/ser_dispatch.sv ----
// Soft error interrupt dispatch: raises the request at the soft level
// and, once the core takes it, pushes the two-word frame.
// Assumes take_i is a one-cycle pulse from the core on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ser_dispatch (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pend_i,
   input wire logic take_i,
   input wire logic [31:0] pc_i,
   input wire logic [31:0] psl_i,
   output logic req_o,
   output logic [4:0] ipl_o,
   output logic [7:0] vec_o,
   output logic push_o,
   output logic [31:0] push_data_o
);
   // Whole state of the sequencer
   typedef struct packed {
      ser_pkg::ser_disp_state_t state;
      logic req;
      logic [4:0] interrupt_priority_level;
      logic [7:0] vec;
      logic push;
      logic [31:0] data;
   } ser_disp_st_t;

   ser_disp_st_t st;
   ser_disp_st_t next_st;

   // Sequencer; PROCESSOR_STATUS_LONGWORD is sampled one cycle after PC, core holds it stable
   always_comb begin
      next_st = st;
      next_st.push = 1'b0;
      unique case (st.state)
         ser_pkg::SER_IDLE: begin
            if (pend_i) begin
               next_st.state = ser_pkg::SER_REQ;
               next_st.req = 1'b1;
               next_st.interrupt_priority_level = ser_pkg::SOFT_IPL;
               next_st.vec = ser_pkg::SOFT_VECTOR;
            end
         end
         ser_pkg::SER_REQ: begin
            // Core accepted: first frame word is the PC
            if (take_i) begin
               next_st.state = ser_pkg::SER_PUSH_PC;
               next_st.req = 1'b0;
               next_st.push = 1'b1;
               next_st.data = pc_i;
            end else if (!pend_i) begin
               // Cause cleared before service: withdraw
               next_st.state = ser_pkg::SER_IDLE;
               next_st.req = 1'b0;
            end
         end
         ser_pkg::SER_PUSH_PC: begin
            next_st.state = ser_pkg::SER_PUSH_PSL;
            next_st.push = 1'b1;
            next_st.data = psl_i;
         end
         ser_pkg::SER_PUSH_PSL: begin
            next_st.state = ser_pkg::SER_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '{state: ser_pkg::SER_IDLE, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign req_o = st.req;
   assign ipl_o = st.interrupt_priority_level;
   assign vec_o = st.vec;
   assign push_o = st.push;
   assign push_data_o = st.data;

   // Frame is exactly two words, PC then PROCESSOR_STATUS_LONGWORD
   frame_two_words_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_o && take_i) |=> push_o && push_data_o == $past(pc_i)
         ##1 push_o && push_data_o == $past(psl_i) ##1 !push_o)
      else $error("frame not two words");

   req_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req_o |-> (ipl_o == 5'h1A && vec_o == 8'h54))
      else $error("request level or vector wrong");

   frame_cov: cover property (@(posedge clk_i) disable iff (rst_i)
      req_o ##1 push_o ##1 push_o);
endmodule : ser_dispatch
`default_nettype wire

// ---- src/ser_pkg.sv ----
// Shared constants of the soft error reporting block: register map,
// status bit layout, reset values and interrupt dispatch codes.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package ser_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00; // Sticky flags, write 1 to clear
   localparam logic [7:0] OFF_MASK = 8'h04; // Interrupt mask
   localparam logic [7:0] OFF_CTRL = 8'h08; // Cache enables
   localparam logic [7:0] OFF_IC_ADDR = 8'h0C; // Icache error address
   localparam logic [7:0] OFF_PC_ADDR = 8'h10; // Primary cache error address
   localparam logic [7:0] OFF_FILL_ADDR = 8'h14; // Fill error address
   localparam logic [7:0] OFF_FILL_SYN = 8'h18; // Fill ECC syndrome

   // Status bit positions
   localparam int ST_IC_DP0 = 0;
   localparam int ST_IC_TP0 = 1;
   localparam int ST_IC_DP1 = 2;
   localparam int ST_IC_TP1 = 3;
   localparam int ST_PC_DP = 4;
   localparam int ST_PC_TPL = 5;
   localparam int ST_PC_TPR = 6;
   localparam int ST_FILL_ECC = 7;
   localparam int ST_PTE_WR = 8;
   localparam int ST_PC_LOCK = 9;
   localparam int ST_IC_LOCK = 10;
   localparam int STAT_W = 11;

   // Control bit positions
   localparam int CT_PC_EN = 0;
   localparam int CT_IC_EN = 1;

   // Reset values
   localparam logic [10:0] MASK_RST = 11'h1FF; // Error events unmasked
   localparam logic [1:0] CTRL_RST = 2'h3; // Both caches enabled

   // Interrupt dispatch codes
   localparam logic [4:0] SOFT_IPL = 5'h1A;
   localparam logic [7:0] SOFT_VECTOR = 8'h54;

   // Dispatch sequencer states
   typedef enum logic [1:0] {
      SER_IDLE = 2'b00,
      SER_REQ = 2'b01,
      SER_PUSH_PC = 2'b10,
      SER_PUSH_PSL = 2'b11
   } ser_disp_state_t;
endpackage : ser_pkg

// ---- src/ser_top.sv ----
// Soft error reporting block: captures soft cache, fill and page-entry
// errors, holds their flags and the cache and fill error addresses, gates both caches and
// requests the soft error interrupt.
// Assumes error inputs come from logic on clk_i (no synchronisers) and a
// classic Wishbone master.
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ser_top #(
   parameter int ADDR_W = 32,
   parameter int SYN_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic int_o,
   // Instruction cache parity events
   input wire logic ic_icache_data_parity_bank_zero_i,
   input wire logic ic_icache_tag_parity_bank_zero_i,
   input wire logic ic_icache_data_parity_bank_one_i,
   input wire logic ic_icache_tag_parity_bank_one_i,
   input wire logic [ADDR_W-1:0] ic_vaddr_i,
   output logic ic_enable_o,
   // Primary data cache reference and parity events
   input wire logic pc_ref_valid_i,
   input wire logic pc_miss_i,
   input wire logic pc_dperr_i,
   input wire logic pc_tperr_left_i,
   input wire logic pc_tperr_right_i,
   input wire logic [ADDR_W-1:0] pc_paddr_i,
   output logic pc_enable_o,
   output logic pc_fwd_miss_o,
   // Fill read ECC events
   input wire logic fill_err_i,
   input wire logic fill_multi_i,
   input wire logic [ADDR_W-1:0] fill_addr_i,
   input wire logic [SYN_W-1:0] fill_syn_i,
   // Page entry read error
   input wire logic pte_err_i,
   input wire logic pte_write_i,
   output logic write_abort_o,
   // Core side of interrupt dispatch
   input wire logic take_i,
   input wire logic [31:0] pc_i,
   input wire logic [31:0] psl_i,
   output logic irq_req_o,
   output logic [4:0] irq_ipl_o,
   output logic [7:0] irq_vec_o,
   output logic push_o,
   output logic [31:0] push_data_o
);
   localparam int SW = ser_pkg::STAT_W;

   // Whole state of the block
   typedef struct packed {
      logic [SW-1:0] status; // Sticky flags
      logic [SW-1:0] mask; // Interrupt mask
      logic [1:0] ctrl; // Cache enables
      logic ack;
      logic [31:0] rdata;
      logic irq;
      logic ic_en;
      logic pc_en;
      logic fwd_miss;
      logic wr_abort;
   } ser_top_st_t;

   ser_top_st_t st;
   ser_top_st_t next_st;

   logic [31:0] wmask; // Byte lanes as bit mask
   logic bus_wr; // Write taken this edge
   logic bus_rd; // Read taken this edge
   logic [SW-1:0] set; // Hardware events this cycle
   logic [SW-1:0] w1c; // Software clears this cycle
   logic pc_tag_err; // Any primary cache tag error
   logic pc_any; // Any primary cache parity error
   logic ic_any; // Any icache parity error
   logic fill_unc; // Uncorrectable fill
   logic ld_ic, ld_pc, ld_fill; // Capture enables
   logic [ADDR_W-1:0] ic_addr_q, pc_addr_q, fill_addr_q;
   logic [SYN_W-1:0] fill_syn_q;
   logic [31:0] rd_mux;

   // Bus decode; one wait state, ack drops after one cycle
   always_comb begin
      wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack;
      bus_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack;
   end

   // Event classification
   always_comb begin
      ic_any = ic_icache_data_parity_bank_zero_i || ic_icache_tag_parity_bank_zero_i || ic_icache_data_parity_bank_one_i || ic_icache_tag_parity_bank_one_i;
      pc_tag_err = pc_tperr_left_i || pc_tperr_right_i;
      pc_any = pc_tag_err || pc_dperr_i;
      fill_unc = fill_err_i && fill_multi_i;
      set = '0;
      set[ser_pkg::ST_IC_DP0] = ic_icache_data_parity_bank_zero_i;
      set[ser_pkg::ST_IC_TP0] = ic_icache_tag_parity_bank_zero_i;
      set[ser_pkg::ST_IC_DP1] = ic_icache_data_parity_bank_one_i;
      set[ser_pkg::ST_IC_TP1] = ic_icache_tag_parity_bank_one_i;
      // Tag wins over data so only one kind is reported
      set[ser_pkg::ST_PC_DP] = pc_dperr_i && !pc_tag_err;
      set[ser_pkg::ST_PC_TPL] = pc_tperr_left_i;
      set[ser_pkg::ST_PC_TPR] = pc_tperr_right_i;
      set[ser_pkg::ST_FILL_ECC] = fill_unc;
      set[ser_pkg::ST_PTE_WR] = pte_err_i && pte_write_i;
      set[ser_pkg::ST_PC_LOCK] = pc_any;
      set[ser_pkg::ST_IC_LOCK] = ic_any;
      w1c = '0;
      if (bus_wr && wb_adr_i == ser_pkg::OFF_STATUS) begin
         w1c = wb_dat_i[SW-1:0] & wmask[SW-1:0];
      end
   end

   // Capture only the first error of a group; later ones must not
   // overwrite what software has yet to read
   always_comb begin
      ld_ic = ic_any && !(|st.status[ser_pkg::ST_IC_TP1:ser_pkg::ST_IC_DP0]);
      ld_pc = pc_any && !(|st.status[ser_pkg::ST_PC_TPR:ser_pkg::ST_PC_DP]);
      ld_fill = fill_unc && !st.status[ser_pkg::ST_FILL_ECC];
   end

   // Icache error address, quadword aligned
   ser_capture #(.W(ADDR_W)) u_ic_addr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(ld_ic),
      .data_i({ic_vaddr_i[ADDR_W-1:3], 3'h0}),
      .q_o(ic_addr_q)
   );

   // Primary cache error physical address
   ser_capture #(.W(ADDR_W)) u_pc_addr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(ld_pc),
      .data_i(pc_paddr_i),
      .q_o(pc_addr_q)
   );

   // Fill error address
   ser_capture #(.W(ADDR_W)) u_fill_addr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(ld_fill),
      .data_i(fill_addr_i),
      .q_o(fill_addr_q)
   );

   // Fill syndrome
   ser_capture #(.W(SYN_W)) u_fill_syn (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(ld_fill),
      .data_i(fill_syn_i),
      .q_o(fill_syn_q)
   );

   // Read multiplexer; unmapped offsets read as zero
   always_comb begin
      rd_mux = '0;
      unique case (wb_adr_i)
         ser_pkg::OFF_STATUS: rd_mux[SW-1:0] = st.status;
         ser_pkg::OFF_MASK: rd_mux[SW-1:0] = st.mask;
         ser_pkg::OFF_CTRL: rd_mux[1:0] = st.ctrl;
         ser_pkg::OFF_IC_ADDR: rd_mux[ADDR_W-1:0] = ic_addr_q;
         ser_pkg::OFF_PC_ADDR: rd_mux[ADDR_W-1:0] = pc_addr_q;
         ser_pkg::OFF_FILL_ADDR: rd_mux[ADDR_W-1:0] = fill_addr_q;
         ser_pkg::OFF_FILL_SYN: rd_mux[SYN_W-1:0] = fill_syn_q;
         default: rd_mux = '0;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      next_st = st;
      next_st.ack = bus_wr || bus_rd;
      if (bus_rd) begin
         next_st.rdata = rd_mux;
      end
      // Set wins over a clear in the same cycle
      next_st.status = (st.status & ~w1c) | set;
      if (bus_wr && wb_adr_i == ser_pkg::OFF_MASK) begin
         next_st.mask = (st.mask & ~wmask[SW-1:0])
                      | (wb_dat_i[SW-1:0] & wmask[SW-1:0]);
      end
      if (bus_wr && wb_adr_i == ser_pkg::OFF_CTRL && wb_sel_i[0]) begin
         next_st.ctrl = wb_dat_i[1:0];
      end
      next_st.irq = |(st.status & st.mask);
      // Cache stays off while its lock is set
      next_st.pc_en = st.ctrl[ser_pkg::CT_PC_EN]
                    && !next_st.status[ser_pkg::ST_PC_LOCK];
      next_st.ic_en = st.ctrl[ser_pkg::CT_IC_EN]
                    && !next_st.status[ser_pkg::ST_IC_LOCK];
      // Errored reference goes on as a miss, so no data is lost
      next_st.fwd_miss = pc_ref_valid_i && (pc_miss_i || pc_any);
      // One abort pulse; the write is dropped, never retried
      next_st.wr_abort = pte_err_i && pte_write_i;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '{mask: ser_pkg::MASK_RST, ctrl: ser_pkg::CTRL_RST,
                 default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.rdata;
   assign int_o = st.irq;
   assign ic_enable_o = st.ic_en;
   assign pc_enable_o = st.pc_en;
   assign pc_fwd_miss_o = st.fwd_miss;
   assign write_abort_o = st.wr_abort;

   // Interrupt request and frame push
   ser_dispatch u_dispatch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pend_i(st.irq),
      .take_i(take_i),
      .pc_i(pc_i),
      .psl_i(psl_i),
      .req_o(irq_req_o),
      .ipl_o(irq_ipl_o),
      .vec_o(irq_vec_o),
      .push_o(push_o),
      .push_data_o(push_data_o)
   );

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Only while the cause stays pending; a clear may withdraw the request
   soft_irq_a: assert property (
      (|(st.status & st.mask)) [*2] |-> int_o
         ##1 (irq_req_o || push_o || $past(push_o)))
      else $error("pending error gave no request");

   ic_flags_a: assert property (
      (ic_icache_tag_parity_bank_one_i && ic_icache_data_parity_bank_zero_i) |=> st.status[3] && st.status[0])
      else $error("icache flag not set");

   ic_addr_a: assert property (
      (ic_any && st.status[3:0] == 4'h0) |=>
         ic_addr_q == {$past(ic_vaddr_i[ADDR_W-1:3]), 3'h0})
      else $error("icache address not captured");

   pc_one_kind_a: assert property (
      (pc_dperr_i && pc_tag_err && !st.status[4]) |=> !st.status[4])
      else $error("data and tag both reported");

   pc_fwd_miss_a: assert property (
      (pc_ref_valid_i && pc_any) |=> pc_fwd_miss_o)
      else $error("errored reference not forwarded");

   pc_lock_off_a: assert property (
      pc_any |=> st.status[9] && !pc_enable_o)
      else $error("lock did not disable cache");

   pc_addr_a: assert property (
      (pc_any && st.status[6:4] == 3'h0) |=> pc_addr_q == $past(pc_paddr_i))
      else $error("primary cache address not captured");

   fill_single_a: assert property (
      (fill_err_i && !fill_multi_i && !st.status[7]) |=> !st.status[7])
      else $error("correctable fill flagged");

   fill_capture_a: assert property (
      (fill_unc && !st.status[7]) |=> st.status[7]
         && fill_syn_q == $past(fill_syn_i)
         && fill_addr_q == $past(fill_addr_i))
      else $error("fill syndrome or address lost");

   pte_flag_a: assert property (
      (pte_err_i && pte_write_i) |=> st.status[8])
      else $error("page entry write flag not set");

   pte_abort_a: assert property (
      (pte_err_i && pte_write_i) |=> write_abort_o)
      else $error("write not abandoned");

   fill_hold_a: assert property (
      (st.status[7] && !w1c[7]) |=> st.status[7] && $stable(fill_addr_q))
      else $error("fill flag or address not held");

   lock_cov: cover property (pc_any ##1 !pc_enable_o ##[1:20] pc_enable_o);
   fill_cov: cover property (fill_unc ##[1:20] w1c[7]);
   abort_cov: cover property (pte_err_i && pte_write_i ##1 write_abort_o);
endmodule : ser_top
`default_nettype wire
